// ==== src/tss_regs.svh ====
// Register offsets, field positions and reset values of the source select block
`ifndef TSS_REGS_SVH
`define TSS_REGS_SVH
// Register indices; one aligned 32-bit word per register
`define TSS_IDX_SRC_SEL    12'h016
`define TSS_IDX_DRV_CTRL   12'h014
`define TSS_IDX_STATUS     12'h010
// Byte addresses on the bus are four times the index
`define TSS_ADDR_SRC_SEL   12'h058
`define TSS_ADDR_DRV_CTRL  12'h050
`define TSS_ADDR_STATUS    12'h040
`define TSS_SRC_SEL_RESET  8'h10
`define TSS_SRC_SEL_MASK   8'h3F
`define TSS_DRV_CTRL_RESET 8'h00
`define TSS_DRV_MSB        5
`define TSS_DRV_LSB        4
`define TSS_AUX_MSB        3
`define TSS_AUX_LSB        0
`define TSS_INV2_ON_BIT    7
`define TSS_INV1_ON_BIT    6
`define TSS_INV2_OFF_BIT   5
`define TSS_INV1_OFF_BIT   4
`define TSS_EN2_BIT        1
`define TSS_EN1_BIT        0
`endif

// ==== src/tss_pkg.sv ====
// Types shared by the source select block
package tss_pkg;
  // Driver source codes
  typedef enum logic [1:0]
  {
    TSS_DRV_TRI    = 2'h0,
    TSS_DRV_CODER  = 2'h1,
    TSS_DRV_AUXIN  = 2'h2,
    TSS_DRV_HIGH   = 2'h3
  } tss_drv_e;

  // Internal signals that may be routed to the auxiliary pin
  typedef struct packed
  {
    logic test_bus_bit;
    logic coder_env;
    logic tx_serial;
    logic rx_regen;
    logic rx_serial;
    logic sam_b_rx;
    logic sam_b_tx;
    logic demod_cmp;
    logic sam_a_rx;
    logic sam_a_tx;
    logic sam_a_rx_unf;
    logic sam_a_env_unf;
  } tss_sig_s;

  // One driven pin value with its enable
  typedef struct packed
  {
    logic value;
    logic oe;
  } tss_pin_s;
endpackage

// ==== src/tss_aux_mux.sv ====
// Auxiliary output source multiplexer
`timescale 1ns/1ns
module tss_aux_mux
  import tss_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] sel,
  input  wire tss_sig_s   sig,
  input  wire logic       rx_active,
  output tss_pin_s        pin
);
  tss_pin_s next_pin;   // Combinational selection
  tss_pin_s pin_q;      // Registered pin value

  // Select the source; codes 6, 8 and C are gated by receiving state
  always_comb
  begin
    next_pin = '{value: 1'b0, oe: 1'b1};
    case (sel)
      4'h0: next_pin.oe = 1'b0;                          // RULE_05
      4'h1: next_pin.value = 1'b0;                       // RULE_05
      4'h2: next_pin.value = 1'b1;                       // RULE_05
      4'h3: next_pin.value = sig.test_bus_bit;           // RULE_06
      4'h4: next_pin.value = sig.coder_env;              // RULE_07
      4'h5: next_pin.value = sig.tx_serial;              // RULE_07
      4'h6: next_pin.value = sig.rx_regen & rx_active;   // RULE_08 RULE_09
      4'h7: next_pin.value = sig.rx_serial;              // RULE_11
      4'h8: next_pin.value = sig.sam_b_rx & rx_active;   // RULE_12 RULE_09
      4'h9: next_pin.value = sig.sam_b_tx;               // RULE_12
      4'hA: next_pin.value = sig.demod_cmp;              // RULE_12
      4'hB: next_pin.value = 1'b0;                       // Reserved code drives low
      4'hC: next_pin.value = sig.sam_a_rx & rx_active;   // RULE_13 RULE_09
      4'hD: next_pin.value = sig.sam_a_tx;               // RULE_13
      4'hE: next_pin.value = sig.sam_a_rx_unf;           // RULE_13
      4'hF: next_pin.value = sig.sam_a_env_unf;          // RULE_13
      default: next_pin.oe = 1'b0;
    endcase
  end

  // Register so the pin is glitch free
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_q <= '{value: 1'b0, oe: 1'b0};
    else
      pin_q <= next_pin;
  end

  assign pin = pin_q;

  // Pin checks look one cycle back, since the pin is registered after the selection
  a_aux_tristate: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
    ($past(sel) == 4'h0) |-> !pin.oe) else $error("aux pin not tristated");
  a_aux_high: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
    ($past(sel) == 4'h2) |-> (pin.oe && pin.value)) else $error("aux pin not high");
  a_aux_rx_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    ($past(sel) == 4'h6 && !$past(rx_active)) |-> !pin.value) else $error("rx output not gated");
endmodule

// ==== src/tss_top.sv ====
// Driver and auxiliary output source selection with APB registers
`timescale 1ns/1ns
`include "tss_regs.svh"
// Summary of operation
// RULE_01 - Code 00 tristates drivers; 01 uses coder
// RULE_02 - Power-down tristates drivers only with 00
// RULE_03 - Code 10 feeds drivers from aux input
// RULE_04 - Code 11 drives high, then inversion applies
// RULE_05 - Aux codes 0000 tristate, 0001 low, 0010 high
// RULE_06 - Aux code 0011 routes chosen test bit
// RULE_07 - Aux 0100 coder envelope, 0101 transmit stream
// RULE_08 - Aux 0110 outputs regenerated card modulation
// RULE_09 - Receive-derived aux outputs valid only receiving
// RULE_10 - Host avoids 0110 in type A 106k
// RULE_11 - Aux 0111 outputs received serial stream
// RULE_12 - Aux 1000-1011 are type B module group
// RULE_13 - Aux 1100-1111 are type A module group
// RULE_14 - Bits 7 and 6 read zero, ignored
// RULE_15 - Source register resets to 10h
// RULE_16 - Inversion bits invert driver on or off
// RULE_17 - New source applies cycle after write
module tss_top
  import tss_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        aux_input_pin,
  input  wire logic        coder_env,
  input  wire logic        soft_power_down,
  input  wire logic        rx_active,
  input  wire tss_sig_s    aux_sources,
  output logic             antenna_driver_one,
  output logic             antenna_driver_one_oe,
  output logic             antenna_driver_two,
  output logic             antenna_driver_two_oe,
  output logic             aux_output_pin,
  output logic             aux_output_pin_oe
);
  // Register state
  logic [7:0]  tx_source_select;        // Source select register
  logic [7:0]  drv_control;             // Inversion and enable bits
  logic [7:0]  next_tx_source_select;
  logic [7:0]  next_drv_control;
  logic [31:0] next_prdata;
  logic [31:0] prdata_q;
  logic        next_pslverr;
  logic        pslverr_q;

  // Pin synchronisers
  logic        auxin_s1;                // First stage, read only by second
  logic        auxin_s2;

  // Driver state
  tss_pin_s    drv1_q;
  tss_pin_s    drv2_q;
  tss_pin_s    next_drv1;
  tss_pin_s    next_drv2;
  tss_pin_s    aux_pin;

  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;

  // Apply byte lane 0 of a write under its strobe
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
                                       input logic [3:0] s, input logic [7:0] msk);
    lane0 = s[0] ? (d[7:0] & msk) : old;
  endfunction

  // Driver level after inversion; inversion depends on enable state
  function automatic logic drv_level(input logic src, input logic en,
                                     input logic inv_on, input logic inv_off);
    drv_level = src ^ (en ? inv_on : inv_off);
  endfunction

  assign pready  = 1'b1;                // Zero wait state slave
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign addr_ok = (paddr == `TSS_ADDR_SRC_SEL) || (paddr == `TSS_ADDR_DRV_CTRL)
                   || (paddr == `TSS_ADDR_STATUS);

  // Register write path; only the addressed register changes
  always_comb
  begin
    next_tx_source_select = tx_source_select;
    next_drv_control      = drv_control;
    if (wr_en && paddr == `TSS_ADDR_SRC_SEL)
      next_tx_source_select = lane0(tx_source_select, pwdata, pstrb, `TSS_SRC_SEL_MASK); // RULE_14 RULE_17
    if (wr_en && paddr == `TSS_ADDR_DRV_CTRL)
      next_drv_control = lane0(drv_control, pwdata, pstrb, 8'hFF);
  end

  // Read path; status shows live driver and aux state
  always_comb
  begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (psel && !penable)
    begin
      case (paddr)
        `TSS_ADDR_SRC_SEL:  next_prdata = {24'h00_0000, tx_source_select & `TSS_SRC_SEL_MASK}; // RULE_14
        `TSS_ADDR_DRV_CTRL: next_prdata = {24'h00_0000, drv_control};
        `TSS_ADDR_STATUS:   next_prdata = {26'h000_0000, aux_pin.oe, aux_pin.value,
                                           drv2_q.oe, drv2_q.value, drv1_q.oe, drv1_q.value};
        default:            next_prdata = 32'h0000_0000;
      endcase
      next_pslverr = ~addr_ok;          // Unmapped address answers with error
    end
  end

  // Register flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_source_select <= `TSS_SRC_SEL_RESET;  // RULE_15
      drv_control      <= `TSS_DRV_CTRL_RESET;
      prdata_q         <= 32'h0000_0000;
      pslverr_q        <= 1'b0;
    end
    else
    begin
      tx_source_select <= next_tx_source_select;
      drv_control      <= next_drv_control;
      prdata_q         <= (psel && !penable) ? next_prdata : prdata_q;
      pslverr_q        <= (psel && !penable) ? next_pslverr : pslverr_q;
    end
  end

  assign prdata  = rd_en ? prdata_q : 32'h0000_0000;
  assign pslverr = psel & penable & pslverr_q;

  // Two-flop synchroniser for the aux input pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      auxin_s1 <= 1'b0;
      auxin_s2 <= 1'b0;
    end
    else
    begin
      auxin_s1 <= aux_input_pin;
      auxin_s2 <= auxin_s1;
    end
  end

  // Driver source selection and inversion
  always_comb
  begin
    logic src;
    logic drive;
    src   = 1'b0;
    drive = 1'b1;
    case (tss_drv_e'(tx_source_select[`TSS_DRV_MSB:`TSS_DRV_LSB]))
      TSS_DRV_TRI:   drive = 1'b0;       // RULE_01 RULE_02
      TSS_DRV_CODER: src = coder_env;    // RULE_01
      TSS_DRV_AUXIN: src = auxin_s2;     // RULE_03
      TSS_DRV_HIGH:  src = 1'b1;         // RULE_04
      default:       drive = 1'b0;
    endcase
    // Power-down keeps the selected source; only code 00 tristates
    next_drv1.oe    = drive;             // RULE_02
    next_drv2.oe    = drive;
    next_drv1.value = drive & drv_level(src, drv_control[`TSS_EN1_BIT],
                                        drv_control[`TSS_INV1_ON_BIT], drv_control[`TSS_INV1_OFF_BIT]); // RULE_16
    next_drv2.value = drive & drv_level(src, drv_control[`TSS_EN2_BIT],
                                        drv_control[`TSS_INV2_ON_BIT], drv_control[`TSS_INV2_OFF_BIT]); // RULE_16
  end

  // Driver output flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drv1_q <= '{value: 1'b0, oe: 1'b0};
      drv2_q <= '{value: 1'b0, oe: 1'b0};
    end
    else
    begin
      drv1_q <= next_drv1;
      drv2_q <= next_drv2;
    end
  end

  // Auxiliary output multiplexer
  tss_aux_mux u_aux
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .sel       (tx_source_select[`TSS_AUX_MSB:`TSS_AUX_LSB]),
    .sig       (aux_sources),
    .rx_active (rx_active),
    .pin       (aux_pin)
  );

  assign antenna_driver_one    = drv1_q.value;
  assign antenna_driver_one_oe = drv1_q.oe;
  assign antenna_driver_two    = drv2_q.value;
  assign antenna_driver_two_oe = drv2_q.oe;
  assign aux_output_pin        = aux_pin.value;
  assign aux_output_pin_oe     = aux_pin.oe;

  // Register and pin checks; pin checks look one cycle back because the pins are registered
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
    tx_source_select[7:6] == 2'h0) else $error("reserved bits set");
  a_drv_tristate: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    ($past(tx_source_select[5:4]) == 2'h0) |-> (!antenna_driver_one_oe && !antenna_driver_two_oe))
    else $error("drivers not tristated");
  // Driver flops still show their reset value one edge after release, so that edge is skipped
  a_pd_keeps: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
    ($past(presetn) && $past(soft_power_down) && $past(tx_source_select[5:4]) != 2'h0)
    |-> (antenna_driver_one_oe && antenna_driver_two_oe))
    else $error("power down dropped driver");
  a_drv_high_inv: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    ($past(tx_source_select[5:4]) == 2'h3) |->
    (antenna_driver_one == !($past(drv_control[0]) ? $past(drv_control[6]) : $past(drv_control[4]))))
    else $error("high code level wrong");
  // Coder path on driver one: level is the envelope after the inversion picked by the enable
  a_drv_coder: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    ($past(presetn) && $past(tx_source_select[5:4]) == 2'h1) |->
    (antenna_driver_one == ($past(coder_env) ^ ($past(drv_control[0]) ? $past(drv_control[6])
                                                                      : $past(drv_control[4])))))
    else $error("coder level wrong");
  // Aux input path on driver two, taken after the synchroniser
  a_drv_auxin: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
    ($past(presetn) && $past(tx_source_select[5:4]) == 2'h2) |->
    (antenna_driver_two == ($past(auxin_s2) ^ ($past(drv_control[1]) ? $past(drv_control[7])
                                                                     : $past(drv_control[5])))))
    else $error("aux input level wrong");
  a_write_applies: assert property (@(posedge pclk) disable iff (!presetn) // RULE_17
    (wr_en && paddr == `TSS_ADDR_SRC_SEL && pstrb[0]) |=> (tx_source_select == ($past(pwdata[7:0]) & 8'h3F)))
    else $error("source write lost");
  // A write to an unmapped address must leave the source selection alone
  a_unmapped_keep: assert property (@(posedge pclk) disable iff (!presetn) // RULE_17
    (psel && penable && pwrite && !addr_ok) |=> $stable(tx_source_select))
    else $error("unmapped write changed source");
endmodule

// ==== tb/tss_sam_model.sv ====
// Behavioural secure module on the auxiliary lines
`timescale 1ns/1ns
module tss_sam_model
(
  input  wire logic pclk,
  input  wire logic send,
  input  wire logic level,
  input  wire logic aux_out,
  input  wire logic aux_out_oe,
  output logic      aux_in,
  output logic      seen
);
  // Idle line toggles each cycle, so a stale level can never pass for data
  initial aux_in = 1'b0;
  always @(posedge pclk)
    aux_in <= send ? level : ~aux_in;
  // Capture what the reader presents while it drives the line
  always @(posedge pclk)
    if (aux_out_oe)
      seen <= aux_out;
endmodule

// ==== tb/tss_top_bench.sv ====
// Self-checking bench for the source select block
`timescale 1ns/1ns
`include "tss_regs.svh"
module tss_top_bench;
  import tss_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        aux_in, cenv, spd, rx, send, lvl, d1, d1_oe, d2, d2_oe, ao, ao_oe, seen_w;
  tss_sig_s    src, t;
  logic [7:0]  ctl;
  logic [3:0]  c, strb;
  logic [1:0]  ax;
  integer      err_total, compares, cyc, seed, k;

  tss_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .aux_input_pin(aux_in), .coder_env(cenv), .soft_power_down(spd), .rx_active(rx), .aux_sources(src),
    .antenna_driver_one(d1), .antenna_driver_one_oe(d1_oe), .antenna_driver_two(d2),
    .antenna_driver_two_oe(d2_oe), .aux_output_pin(ao), .aux_output_pin_oe(ao_oe));
  tss_sam_model u_sam (.pclk(pclk), .send(send), .level(lvl), .aux_out(ao), .aux_out_oe(ao_oe),
    .aux_in(aux_in), .seen(seen_w));

  always #2 pclk = ~pclk;
  // Hang guard: the whole run needs far fewer cycles
  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (cyc > 6000)
    begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares = compares + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready without assuming a latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Expected aux pin as {value, enable}; gated receive codes read low when idle
  function automatic logic [1:0] aux_exp(input logic [3:0] c, input tss_sig_s s, input logic r);
    logic v;
    case (c)
      4'h0: return 2'b00;
      4'h1, 4'hB: return 2'b01;
      4'h2: return 2'b11;
      4'h3: v = s.test_bus_bit;
      4'h4: v = s.coder_env;
      4'h5: v = s.tx_serial;
      4'h6: v = s.rx_regen & r;
      4'h7: v = s.rx_serial;
      4'h8: v = s.sam_b_rx & r;
      4'h9: v = s.sam_b_tx;
      4'hA: v = s.demod_cmp;
      4'hC: v = s.sam_a_rx & r;
      4'hD: v = s.sam_a_tx;
      4'hE: v = s.sam_a_rx_unf;
      default: v = s.sam_a_env_unf;
    endcase
    return {v, 1'b1};
  endfunction

  // Expected drivers as {v1, oe1, v2, oe2}; inversion picked by each enable
  function automatic logic [3:0] drv_exp(input logic [1:0] c, input logic e, input logic l, input logic [7:0] t);
    logic s;
    s = (c == 2'h1) ? e : (c == 2'h2) ? l : 1'b1;
    if (c == 2'h0)
      return 4'h0;
    return {s ^ (t[0] ? t[6] : t[4]), 1'b1, s ^ (t[1] ? t[7] : t[5]), 1'b1};
  endfunction

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, cenv, spd, rx, send, lvl, src} = '0;
    {err_total, compares, cyc} = '0;
    pclk    = 1'b0;
    strb    = 4'hF;
    seed    = 32'he7774395;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset contents and pins
    apb(1'b0, `TSS_ADDR_SRC_SEL, 32'h0);
    check(rd, 32'h10, "reset value");
    check({d1, d1_oe, d2, d2_oe, ao_oe}, {drv_exp(2'h1, cenv, 1'b0, 8'h0), 1'b0}, "reset pins");
    $display("reset test done");
    // Reserved bits, unmapped access, neighbour write leaves source intact
    apb(1'b1, `TSS_ADDR_SRC_SEL, 32'hFFFFFFFF);
    apb(1'b0, `TSS_ADDR_SRC_SEL, 32'h0);
    check(rd, 32'h3F, "reserved bits");
    check(er, 1'b0, "mapped no error");
    apb(1'b1, 12'h3FC, 32'h5A);
    check(er, 1'b1, "unmapped error");
    apb(1'b1, `TSS_ADDR_DRV_CTRL, 32'hC3);
    apb(1'b0, `TSS_ADDR_SRC_SEL, 32'h0);
    check(rd, 32'h3F, "source kept");
    // A write without the lane 0 strobe must not touch the register
    strb <= 4'hE;
    apb(1'b1, `TSS_ADDR_SRC_SEL, 32'h0);
    strb <= 4'hF;
    apb(1'b0, `TSS_ADDR_SRC_SEL, 32'h0);
    check(rd, 32'h3F, "strobe off write");
    // Timing of a new selection: old value one cycle, new from the next
    apb(1'b1, `TSS_ADDR_SRC_SEL, 32'h12);
    apb(1'b1, `TSS_ADDR_SRC_SEL, 32'h11);
    #1 check(ao, 1'b1, "old aux level");
    @(posedge pclk);
    #1 check(ao, 1'b0, "new aux level");
    $display("register test done");
    // Every driver code with random inversion, enables and power-down
    send <= 1'b1;
    for (k = 0; k < 16; k++)
    begin
      ctl = $random(seed);
      @(posedge pclk);
      lvl  <= $random(seed);
      cenv <= $random(seed);
      spd  <= $random(seed);
      apb(1'b1, `TSS_ADDR_DRV_CTRL, {24'h0, ctl});
      apb(1'b1, `TSS_ADDR_SRC_SEL, {26'h0, k[1:0], 4'h1});
      repeat (5) @(posedge pclk);
      check({d1, d1_oe, d2, d2_oe}, drv_exp(k[1:0], cenv, lvl, ctl), "drivers");
      apb(1'b0, `TSS_ADDR_STATUS, 32'h0);
      check({rd[0], rd[1], rd[2], rd[3]}, drv_exp(k[1:0], cenv, lvl, ctl), "driver status");
    end
    $display("driver test done");
    // Every aux code twice, receiving and idle drawn at random
    send <= 1'b0;
    for (k = 0; k < 32; k++)
    begin
      c = k[3:0];
      t = $random(seed);
      @(posedge pclk);
      src  <= t;
      cenv <= t.coder_env;
      rx   <= $random(seed);
      apb(1'b1, `TSS_ADDR_SRC_SEL, {26'h0, 2'h1, c});
      repeat (3) @(posedge pclk);
      ax = aux_exp(c, src, rx);
      check({ao, ao_oe}, ax, "aux pin");
      if (ax[0])
        check(seen_w, ax[1], "partner sees aux");
      apb(1'b0, `TSS_ADDR_STATUS, 32'h0);
      check({rd[4], rd[5]}, ax, "aux status");
    end
    $display("aux test done");
    // Reset in mid-run with power-down set: source returns to reset value, drivers stay on
    @(posedge pclk);
    presetn <= 1'b0;
    spd     <= 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `TSS_ADDR_SRC_SEL, 32'h0);
    check(rd, 32'h10, "reset again");
    check({d1_oe, d2_oe, ao_oe}, 3'b110, "power-down drivers");
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule
